/* File: rtl/kbcmd_cfg.svh */
`ifndef KBCMD_CFG_SVH
`define KBCMD_CFG_SVH
// Command and answer codes
`define KBCMD_ACK        8'hfa
`define KBCMD_SET_LEDS   8'hed
`define KBCMD_READ_ID    8'hf2
`define KBCMD_SCAN_SET   8'hf0
`define KBCMD_TYPEMATIC  8'hf3
`define KBCMD_FIRST_CMD  8'hed
// Identification bytes: arbitrary values
`define KBCMD_ID0        8'h5a
`define KBCMD_ID1        8'h11
// Scan set codes
`define KBCMD_SET_QUERY  8'h00
`define KBCMD_SET_TWO    8'h02
`define KBCMD_SET_THREE  8'h03
// Lamp bit positions
`define KBCMD_LED_CAPS   2
`define KBCMD_LED_NUM    1
`define KBCMD_LED_SCROLL 0
// Reset values
`define KBCMD_LEDS_RST   3'h0
`define KBCMD_SET_RST    8'h02
`define KBCMD_TM_RST     8'h2b
// Register byte offsets
`define KBCMD_REG_RXDATA 4'h0
`define KBCMD_REG_TXDATA 4'h4
`define KBCMD_REG_STATUS 4'h8
`define KBCMD_REG_CTRL   4'hc
`endif

/* File: rtl/kbcmd_pkg.sv */
package kbcmd_pkg;
   typedef enum logic [2:0] {
      KB_IDLE, KB_WAIT_TM, KB_WAIT_LED, KB_WAIT_SET
   } kbcmd_state_e;
   typedef struct packed {
      logic [7:0] data;
      logic       valid;
   } kbcmd_byte_s;
   typedef struct packed {
      kbcmd_state_e state;
      logic [2:0]   leds;
      logic [7:0]   scan_set;
      logic [7:0]   typematic;
      logic         scanning;
      logic         was_halted;
      logic [7:0]   q0;
      logic [7:0]   q1;
      logic [7:0]   q2;
      logic [1:0]   qcnt;
      logic [7:0]   rx_data;
      logic         rx_pend;
      logic         ack;
      logic [31:0]  rdat;
   } kbcmd_st_s;
endpackage : kbcmd_pkg

/* File: rtl/kbcmd_core.sv */
// How it works
// - A valid typematic parameter byte is answered with the acknowledge code.
// - After the typematic byte, scanning restarts only if it was running when the command came.
// - The first lamp command byte stops scanning, sends the acknowledge code and waits for a second byte.
// - A second lamp byte of ED or above drops the lamp command, keeps the lamps and runs as a new command.
// - Otherwise the new lamp states come only from the three low bits of that byte.
// - A one lights a lamp and a zero darkens it: bit 2 caps, bit 1 num, bit 0 scroll, bits 7-3 unused.
// - A lamp byte is acknowledged, the lamps updated, and scanning resumed only if it ran before.
// - All three lamps are off by default.
// - The identification read answers the acknowledge code then two fixed identity bytes in order.
// - The identification read does not stop scanning: it keeps the state it had before.
// - The scan set command is acknowledged and an option byte is awaited.
// - The option byte is acknowledged before it is acted on.
// - Option zero reports the current scan set as 02 or 03.
// - Option 02 or 03 switches the active scan set.
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`include "kbcmd_cfg.svh"
module kbcmd_core
   import kbcmd_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   output logic             caps_led_o,
   output logic             num_led_o,
   output logic             scroll_led_o,
   output logic             scan_en_o
);

   kbcmd_st_s   st;
   kbcmd_st_s   next_st;
   logic        req;
   logic        wr_rx;
   logic        rd_tx;
   kbcmd_byte_s cmd;

   // True for any byte the keyboard treats as a command
   function automatic logic is_cmd(input logic [7:0] b);
      return b >= `KBCMD_FIRST_CMD;
   endfunction : is_cmd

   ////////////////////////////////////////////////////////////////////////
   // Bus decode; one-cycle answer, ack dropped the cycle after
   assign req   = cyc_i && stb_i && !st.ack;
   assign wr_rx = req && we_i && sel_i[0] && adr_i == `KBCMD_REG_RXDATA;
   assign rd_tx = req && !we_i && adr_i == `KBCMD_REG_TXDATA;
   assign cmd.data  = st.rx_data;
   assign cmd.valid = st.rx_pend;

   ////////////////////////////////////////////////////////////////////////
   // Next state: command interpreter, reply queue and registers
   always_comb begin
      logic [7:0] pushv [0:2];
      logic [1:0] pushn;
      logic [1:0] qc;
      pushv[0] = 8'h00;
      pushv[1] = 8'h00;
      pushv[2] = 8'h00;
      pushn    = 2'h0;
      next_st  = st;
      next_st.ack  = req;
      next_st.rdat = 32'h0000_0000;
      // Pop the reply queue when software reads it
      qc = st.qcnt;
      if (rd_tx && st.qcnt != 2'h0) begin
         next_st.q0 = st.q1;
         next_st.q1 = st.q2;
         qc = st.qcnt - 2'h1;
      end
      if (cmd.valid) begin
         next_st.rx_pend = 1'b0;
         case (st.state)
            KB_WAIT_TM: begin
               // analog: a high byte aborts and is rerun as a command
               if (cmd.data[7]) begin
                  next_st.state = KB_IDLE;
                  next_st.rx_pend = 1'b1;
               end else begin
                  pushv[0] = `KBCMD_ACK;
                  pushn = 2'h1;
                  next_st.typematic = cmd.data;
                  next_st.scanning = !st.was_halted;
                  next_st.state = KB_IDLE;
               end
            end
            KB_WAIT_LED: begin
               if (is_cmd(cmd.data)) begin
                  next_st.state = KB_IDLE;
                  next_st.rx_pend = 1'b1;
                  next_st.scanning = !st.was_halted;
               end else begin
                  pushv[0] = `KBCMD_ACK;
                  pushn = 2'h1;
                  next_st.leds = cmd.data[2:0];
                  next_st.scanning = !st.was_halted;
                  next_st.state = KB_IDLE;
               end
            end
            KB_WAIT_SET: begin
               pushv[0] = `KBCMD_ACK;
               pushn = 2'h1;
               next_st.state = KB_IDLE;
               next_st.scanning = !st.was_halted;
               if (cmd.data == `KBCMD_SET_QUERY) begin
                  pushv[1] = st.scan_set;
                  pushn = 2'h2;
               end
               if (cmd.data == `KBCMD_SET_TWO || cmd.data == `KBCMD_SET_THREE) begin
                  next_st.scan_set = cmd.data;
               end
            end
            KB_IDLE: begin
               next_st.was_halted = !st.scanning;
               case (cmd.data)
                  `KBCMD_TYPEMATIC: begin
                     pushv[0] = `KBCMD_ACK;
                     pushn = 2'h1;
                     next_st.scanning = 1'b0;
                     next_st.state = KB_WAIT_TM;
                  end
                  `KBCMD_SET_LEDS: begin
                     pushv[0] = `KBCMD_ACK;
                     pushn = 2'h1;
                     next_st.scanning = 1'b0;
                     next_st.state = KB_WAIT_LED;
                  end
                  `KBCMD_READ_ID: begin
                     pushv[0] = `KBCMD_ACK;
                     pushv[1] = `KBCMD_ID0;
                     pushv[2] = `KBCMD_ID1;
                     pushn = 2'h3;
                     next_st.scanning = st.scanning;
                  end
                  `KBCMD_SCAN_SET: begin
                     pushv[0] = `KBCMD_ACK;
                     pushn = 2'h1;
                     next_st.scanning = 1'b0;
                     next_st.state = KB_WAIT_SET;
                  end
                  default: begin
                     // Other codes are ignored and get no reply
                     next_st.state = KB_IDLE;
                  end
               endcase
            end
            default: next_st.state = KB_IDLE;
         endcase
      end
      // Append replies; queue holds three bytes, overflow drops newest
      for (int i = 0; i < 3; i++) begin
         if (2'(i) < pushn && qc != 2'h3) begin
            case (qc)
               2'h0: next_st.q0 = pushv[i];
               2'h1: next_st.q1 = pushv[i];
               default: next_st.q2 = pushv[i];
            endcase
            qc = qc + 2'h1;
         end
      end
      next_st.qcnt = qc;
      // Host byte written by software; ignored while one is pending
      if (wr_rx && !st.rx_pend) begin
         next_st.rx_data = dat_i[7:0];
         next_st.rx_pend = 1'b1;
      end
      // Control register: bit 0 scanning enable
      if (req && we_i && sel_i[0] && adr_i == `KBCMD_REG_CTRL && st.state == KB_IDLE) begin
         next_st.scanning = dat_i[0];
      end
      // Read data
      if (req && !we_i) begin
         case (adr_i)
            `KBCMD_REG_RXDATA: next_st.rdat = {24'h0, st.rx_data};
            `KBCMD_REG_TXDATA: next_st.rdat = {22'h0, st.qcnt, st.q0};
            `KBCMD_REG_STATUS: next_st.rdat = {13'h0, st.leds, st.scan_set, st.typematic};
            // Bit 3 flags any non-idle state; a plain width cast would only keep the low state bit
            `KBCMD_REG_CTRL:   next_st.rdat = {28'h0, st.state != KB_IDLE, st.rx_pend, st.was_halted, st.scanning};
            default:           next_st.rdat = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; lamps off after reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st            <= '0;
         st.state      <= KB_IDLE;
         st.leds       <= `KBCMD_LEDS_RST;
         st.scan_set   <= `KBCMD_SET_RST;
         st.typematic  <= `KBCMD_TM_RST;
         st.scanning   <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from flip-flops
   // lamp bit mapping
   assign caps_led_o   = st.leds[`KBCMD_LED_CAPS];
   assign num_led_o    = st.leds[`KBCMD_LED_NUM];
   assign scroll_led_o = st.leds[`KBCMD_LED_SCROLL];
   assign scan_en_o    = st.scanning;
   assign dat_o        = st.rdat;
   assign ack_o        = st.ack;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   lamp_update_a: assert property (
      cmd.valid && st.state == KB_WAIT_LED && !is_cmd(cmd.data)
      |=> st.leds == $past(cmd.data[2:0])
   ) else $error("lamps not updated");

   lamp_abort_a: assert property (
      cmd.valid && st.state == KB_WAIT_LED && is_cmd(cmd.data)
      |=> $stable(st.leds)
   ) else $error("lamps changed on abort");

   abort_resume_a: assert property (
      cmd.valid && st.state == KB_WAIT_LED && is_cmd(cmd.data)
      |=> scan_en_o == !$past(st.was_halted)
   ) else $error("bad abort resume");

   led_halt_a: assert property (
      cmd.valid && st.state == KB_IDLE && cmd.data == `KBCMD_SET_LEDS
      |=> !scan_en_o && st.state == KB_WAIT_LED
   ) else $error("scan not halted");

   led_ack_a: assert property (
      cmd.valid && st.state == KB_WAIT_LED && !is_cmd(cmd.data) && st.qcnt == 2'h0
      |=> st.q0 == `KBCMD_ACK
   ) else $error("no lamp ack");

   led_resume_a: assert property (
      cmd.valid && st.state == KB_WAIT_LED && !is_cmd(cmd.data)
      |=> scan_en_o == !$past(st.was_halted)
   ) else $error("bad lamp resume");

   tm_halt_a: assert property (
      cmd.valid && st.state == KB_IDLE && cmd.data == `KBCMD_TYPEMATIC
      |=> !scan_en_o && st.state == KB_WAIT_TM
   ) else $error("typematic not halted");

   resume_a: assert property (
      cmd.valid && st.state == KB_WAIT_TM && !cmd.data[7]
      |=> scan_en_o == !$past(st.was_halted)
   ) else $error("bad resume");

   tm_ack_a: assert property (
      cmd.valid && st.state == KB_WAIT_TM && !cmd.data[7] && st.qcnt == 2'h0
      |=> st.q0 == `KBCMD_ACK
   ) else $error("no typematic ack");

   // invalid parameter is rerun, setting kept
   tm_abort_a: assert property (
      cmd.valid && st.state == KB_WAIT_TM && cmd.data[7]
      |=> st.state == KB_IDLE && cmd.valid && $stable(st.typematic)
   ) else $error("bad typematic abort");

   id_reply_a: assert property (
      cmd.valid && st.state == KB_IDLE && cmd.data == `KBCMD_READ_ID && st.qcnt == 2'h0 && !rd_tx
      |=> st.q0 == `KBCMD_ACK && st.q1 == `KBCMD_ID0 && st.q2 == `KBCMD_ID1
   ) else $error("bad id");

   id_scan_a: assert property (
      cmd.valid && st.state == KB_IDLE && cmd.data == `KBCMD_READ_ID
      |=> $stable(scan_en_o)
   ) else $error("id scan changed");

   set_wait_a: assert property (
      cmd.valid && st.state == KB_IDLE && cmd.data == `KBCMD_SCAN_SET
      |=> st.state == KB_WAIT_SET
   ) else $error("no option wait");

   set_halt_a: assert property (
      cmd.valid && st.state == KB_IDLE && cmd.data == `KBCMD_SCAN_SET
      |=> !scan_en_o
   ) else $error("scan set not halted");

   set_ack_a: assert property (
      cmd.valid && st.state == KB_WAIT_SET && st.qcnt == 2'h0
      |=> st.q0 == `KBCMD_ACK
   ) else $error("no option ack");

   set_query_a: assert property (
      cmd.valid && st.state == KB_WAIT_SET && cmd.data == `KBCMD_SET_QUERY && st.qcnt == 2'h0 && !rd_tx
      |=> st.q0 == `KBCMD_ACK && st.q1 == $past(st.scan_set)
   ) else $error("bad query");

   set_change_a: assert property (
      cmd.valid && st.state == KB_WAIT_SET && cmd.data == `KBCMD_SET_THREE
      |=> st.scan_set == `KBCMD_SET_THREE
   ) else $error("set not switched");

   set_two_a: assert property (
      cmd.valid && st.state == KB_WAIT_SET && cmd.data == `KBCMD_SET_TWO
      |=> st.scan_set == `KBCMD_SET_TWO
   ) else $error("set two not switched");

   // other options leave the set alone
   set_keep_a: assert property (
      cmd.valid && st.state == KB_WAIT_SET && cmd.data != `KBCMD_SET_TWO && cmd.data != `KBCMD_SET_THREE
      |=> $stable(st.scan_set)
   ) else $error("set changed");

   halt_flag_a: assert property (
      cmd.valid && st.state == KB_IDLE
      |=> st.was_halted == !$past(st.scanning)
   ) else $error("halt flag");

   // Bus answer is a single-cycle pulse
   bus_ack_a: assert property (
      ack_o |=> !ack_o
   ) else $error("ack held");

   // Main scenarios reached
   cov_led: cover property (st.state == KB_WAIT_LED ##1 st.state == KB_IDLE);
   cov_id: cover property (cmd.valid && cmd.data == `KBCMD_READ_ID);
   cov_set: cover property (st.state == KB_WAIT_SET ##1 st.qcnt == 2'h2);
   cov_abort: cover property (cmd.valid && st.state == KB_WAIT_LED && is_cmd(cmd.data));
   cov_tm: cover property (cmd.valid && st.state == KB_WAIT_TM && !cmd.data[7]);
endmodule : kbcmd_core

/* File: test/kbcmd_host.sv */
`timescale 1ns/10ps
`include "kbcmd_cfg.svh"
module kbcmd_host (
   input  wire logic        clk_i,
   input  wire logic [31:0] dat_i,
   input  wire logic        ack_i,
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic [3:0]       adr_o,
   output logic [3:0]       sel_o,
   output logic [31:0]      dat_o
);
   // Bus idle from time zero
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o  = 1'b0;
      adr_o = 4'h0;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end
   ////////////////////////////////////////////////////////////
   // Classic cycle, request held until ack is sampled high
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= w;
      adr_o <= a;
      sel_o <= 4'hf;
      dat_o <= d;
      do @(posedge clk_i); while (ack_i !== 1'b1);
      r = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      // Stale data never left on the bus
      dat_o <= ~d;
   endtask : bus
   // Poll the reply queue until a byte is there, popping it
   task automatic get(output logic [7:0] b);
      logic [31:0] r;
      r = 32'h0;
      while (r[9:8] == 2'b00) bus(1'b0, `KBCMD_REG_TXDATA, 32'h0, r);
      b = r[7:0];
   endtask : get
   // next byte only after the answer
   task automatic send(input logic [7:0] c, output logic [7:0] b);
      logic [31:0] r;
      bus(1'b1, `KBCMD_REG_RXDATA, {24'h0, c}, r);
      get(b);
   endtask : send
endmodule : kbcmd_host

/* File: test/tb_keyboard_host_command_handler.sv */
`timescale 1ns/10ps
`include "kbcmd_cfg.svh"
module tb_keyboard_host_command_handler;
   logic        clk_i;
   logic        rst_i;
   logic        cyc, stb, we, ack;
   logic [3:0]  adr, sel;
   logic [31:0] wdat, rdat, r;
   logic        caps, num, scroll, scan;
   logic [7:0]  b;
   int          n_fail;
   int          tests_run;
   wire  [31:0] outs = {28'h0, caps, num, scroll, scan};

   kbcmd_core DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .caps_led_o(caps), .num_led_o(num),
      .scroll_led_o(scroll), .scan_en_o(scan));
   kbcmd_host host (.clk_i(clk_i), .dat_i(rdat), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we),
      .adr_o(adr), .sel_o(sel), .dat_o(wdat));
   ////////////////////////////////////////////////////////////
   // 25 MHz clock
   initial clk_i = 1'b0;
   always #20 clk_i = ~clk_i;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Send one byte and compare its first reply
   task automatic cmd(input logic [7:0] c, input logic [7:0] e);
      host.send(c, b);
      chk({24'h0, b}, {24'h0, e});
   endtask : cmd
   task automatic rep(input logic [7:0] e);
      host.get(b);
      chk({24'h0, b}, {24'h0, e});
   endtask : rep
   task automatic end_sim();
      if (n_fail == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////
   // Main sequence: lamps, abort, identity, typematic, scan set, halted
   initial begin
      n_fail = 0;
      tests_run = 0;
      rst_i = 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk(outs, 32'h1);
      cmd(`KBCMD_SET_LEDS, `KBCMD_ACK);
      chk(outs, 32'h0);
      host.bus(1'b0, `KBCMD_REG_CTRL, 32'h0, r);
      chk(r, 32'h8);
      // Upper bits set but ignored
      cmd(8'h7a, `KBCMD_ACK);
      chk(outs, 32'h5);
      cmd(`KBCMD_SET_LEDS, `KBCMD_ACK);
      cmd(8'h05, `KBCMD_ACK);
      chk(outs, 32'hb);
      // Second byte is a command: lamps kept
      cmd(`KBCMD_SET_LEDS, `KBCMD_ACK);
      cmd(`KBCMD_READ_ID, `KBCMD_ACK);
      rep(`KBCMD_ID0);
      rep(`KBCMD_ID1);
      chk(outs, 32'hb);
      cmd(`KBCMD_TYPEMATIC, `KBCMD_ACK);
      cmd(8'h20, `KBCMD_ACK);
      chk(outs, 32'hb);
      host.bus(1'b0, `KBCMD_REG_STATUS, 32'h0, r);
      chk(r, {13'h0, 3'h5, `KBCMD_SET_TWO, 8'h20});
      cmd(`KBCMD_SCAN_SET, `KBCMD_ACK);
      cmd(`KBCMD_SET_QUERY, `KBCMD_ACK);
      rep(`KBCMD_SET_TWO);
      cmd(`KBCMD_SCAN_SET, `KBCMD_ACK);
      cmd(`KBCMD_SET_THREE, `KBCMD_ACK);
      cmd(`KBCMD_SCAN_SET, `KBCMD_ACK);
      cmd(`KBCMD_SET_QUERY, `KBCMD_ACK);
      rep(`KBCMD_SET_THREE);
      // Halted before each command: scanning must stay off
      host.bus(1'b1, `KBCMD_REG_CTRL, 32'h0, r);
      cmd(`KBCMD_SET_LEDS, `KBCMD_ACK);
      cmd(8'h02, `KBCMD_ACK);
      chk(outs, 32'h4);
      cmd(`KBCMD_READ_ID, `KBCMD_ACK);
      rep(`KBCMD_ID0);
      rep(`KBCMD_ID1);
      chk(outs, 32'h4);
      cmd(`KBCMD_TYPEMATIC, `KBCMD_ACK);
      cmd(8'h00, `KBCMD_ACK);
      chk(outs, 32'h4);
      // Unmapped place reads zero
      host.bus(1'b0, 4'h2, 32'h0, r);
      chk(r, 32'h0);
      end_sim();
   end
   // Watchdog, far beyond the few hundred cycles needed
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      end_sim();
   end
endmodule : tb_keyboard_host_command_handler
